// ===== angc_pkg.sv
// Package: offsets, field positions, reset values and enumerations for the next-page/gig config slice
package angc_pkg;
    // ==========================================
    // Register indices and byte addresses
    localparam logic [3:0]  IDX_NP_TX      = 4'h7;   // Transmit next page
    localparam logic [3:0]  IDX_NP_RX      = 4'h8;   // Received next page
    localparam logic [3:0]  IDX_GIG_CFG    = 4'h9;   // Gigabit base config
    localparam logic [3:0]  IDX_CTRL       = 4'hc;   // Local control / strap view
    localparam logic [3:0]  IDX_STAT       = 4'hd;   // Page received status
    localparam int          ADDR_LSB       = 2;      // Word aligned
    // ==========================================
    // Reset values
    localparam logic [15:0] NP_TX_RST      = 16'h2001;
    localparam logic [15:0] NP_RX_RST      = 16'h2001;
    localparam logic [15:0] GIG_CFG_RST    = 16'h0300;
    // ==========================================
    // Field positions, next-page words
    localparam int          NP_MORE        = 15;
    localparam int          NP_ACK         = 14;
    localparam int          NP_MSG         = 13;
    localparam int          NP_ACK2        = 12;
    localparam int          NP_TOGGLE      = 11;
    localparam int          NP_PAY_HI      = 10;
    // Writable mask of the transmit word: bits 15,13,12,10..0
    localparam logic [15:0] NP_TX_WMASK    = 16'hb7ff;
    // ==========================================
    // Field positions, gigabit config
    localparam int          CFG_TEST_HI    = 15;
    localparam int          CFG_TEST_LO    = 13;
    localparam int          CFG_MAN_EN     = 12;
    localparam int          CFG_MAN_VAL    = 11;
    localparam int          CFG_PORT       = 10;
    localparam int          CFG_FD         = 9;
    localparam int          CFG_HD         = 8;
    localparam int          CFG_TDR        = 7;
    localparam logic [15:0] GIG_CFG_WMASK  = 16'hff80;
    // Asymmetric pause bit of base pages that seeds the toggles
    localparam int          BASE_ASYM      = 11;
    // ==========================================
    // Test mode encodings
    typedef enum logic [2:0] {
        ANGC_TM_NORMAL  = 3'h0,
        ANGC_TM_WAVE    = 3'h1,
        ANGC_TM_JIT_M   = 3'h2,
        ANGC_TM_JIT_S   = 3'h3,
        ANGC_TM_DIST    = 3'h4,
        ANGC_TM_IDLES   = 3'h5,
        ANGC_TM_P0001   = 3'h6,
        ANGC_TM_PULSE63 = 3'h7
    } angc_test_t;
    // One-hot state of the diagnostic launcher
    typedef enum logic [1:0] {
        ANGC_DG_IDLE = 2'b01,
        ANGC_DG_WAIT = 2'b10
    } angc_diag_t;
endpackage

// ===== angc_sync.sv
// Two-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module angc_sync #(
    parameter int W = 1                  // Bits to synchronise
) (
    input  wire logic         clk,       // Core clock
    input  wire logic         nrst,      // Async reset, active low
    input  wire logic [W-1:0] d,         // Asynchronous input
    output var  logic [W-1:0] q          // Synchronised output
);
    logic [W-1:0] meta_q;                // First stage, read only by second

    // ==========================================
    // Two stages; first is read by nothing else
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ===== angc_regs.sv
// Next-page transmit/receive and gigabit config register slice with APB slave
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Transmit bit 15 requests further next pages
// - Transmit bit 13 message page, reset one
// - Transmit bit 12 sets second acknowledge
// - Transmit toggle read-only, flips, seeded inverted
// - Payload bits 10..0, reset one; rx read-only
// - Received bit 15 shows partner more pages
// - Received bit 14 shows partner acknowledge
// - Received bit 13 message page, reset one
// - Received bit 12 shows partner second ack
// - Received toggle flips, seeded inverted base
// - Test codes zero to four selected
// - Test codes five to seven selected
// - Bit 12 forces manual role
// - Bit 11 picks master or slave
// - Bit 10 declares multi-port device
// - Bit 9 advertises gig full duplex
// - Bit 8 advertises gig half duplex
// - Bit 7 runs cable diagnostic on linkdown
// - Local toggle seed is inverted asymmetric pause bit
// - Partner next pages land at index 8
// - Page received flag latches, clears on read
module angc_regs
    import angc_pkg::*;
#(
    parameter int AW = 12                       // APB address width
) (
    input  wire logic          clk,             // 50 MHz core clock
    input  wire logic          nrst,            // Async reset, active low
    // APB slave
    input  wire logic          psel,            // Select
    input  wire logic          penable,         // Access phase
    input  wire logic          pwrite,          // Write direction
    input  wire logic [AW-1:0] paddr,           // Byte address
    input  wire logic [31:0]   pwdata,          // Write data
    output var  logic          pready,          // Ready
    output var  logic [31:0]   prdata,          // Read data
    output var  logic          pslverr,         // Error on unmapped address
    // Negotiation core side (same clock)
    input  wire logic          np_sent,         // Pulse: transmit page sent
    input  wire logic          np_rx_valid,     // Pulse: partner page validated
    input  wire logic [15:0]   np_rx_word,      // Partner page word
    input  wire logic          np_seed,         // Pulse: new exchange, reseed toggles
    input  wire logic          local_asym_pause,// Local base-page bit 11
    input  wire logic          partner_asym_pause,// Partner base-page bit 11
    // Pins and straps (asynchronous)
    input  wire logic          strap_fd,        // Strap default for full duplex advert
    input  wire logic          strap_hd,        // Strap default for half duplex advert
    input  wire logic          link_up_pin,     // Link status from PMA
    // Outputs to PHY core
    output var  logic [15:0]   np_tx_word,      // Page presented to partner
    output var  logic [2:0]    test_mode,       // Test mode select
    output var  logic          manual_role_enable, // Force role
    output var  logic          manual_role_value,  // 1 master, 0 slave
    output var  logic          multi_port,      // Port type for role resolution
    output var  logic          gig_full_duplex_advert, // Advertise 1000 FD
    output var  logic          gig_half_duplex_advert, // Advertise 1000 HD
    output var  logic          diag_start       // Pulse: launch reflectometry
);
    // ==========================================
    // Storage
    logic [15:0] np_tx_q;                       // Writable part of transmit word
    logic        tx_toggle_q;                   // Transmit toggle
    logic [15:0] np_rx_q;                       // Received word
    logic [15:0] cfg_q;                         // Gigabit config
    logic        page_rx_q;                     // Latched-high page received
    logic        strap_done_q;                  // Straps applied once
    logic [1:0]  strap_s;                       // Synchronised straps
    logic        link_s;                        // Synchronised link status
    logic        link_prev_q;                   // Previous link state
    angc_diag_t  diag_q;                        // Diagnostic launcher state
    // Synchroniser fill tracking; straps are only trusted once both stages hold pin data
    logic [1:0]  settle_cnt_q;                  // Synchroniser fill counter
    logic        settle_q;                      // Straps now valid

    // ==========================================
    // Decode
    logic        wr_en;                         // Write takes effect
    logic        rd_en;                         // Read completes
    logic [3:0]  idx;                           // Word index
    logic        hit;                           // Mapped address
    logic        high_zero;                     // Upper address bits clear
    logic [15:0] rd_word;                       // Selected read word
    logic [15:0] tx_view;                       // Transmit word as read

    assign wr_en     = psel & penable & pwrite;
    assign rd_en     = psel & penable & ~pwrite;
    assign idx       = paddr[ADDR_LSB +: 4];
    assign high_zero = (paddr >> (ADDR_LSB + 4)) == '0;

    // Reserved bit 14 always reads zero
    always_comb begin
        tx_view            = np_tx_q & NP_TX_WMASK;
        tx_view[NP_TOGGLE] = tx_toggle_q;
    end

    // Read mux; unmapped gives zero plus error
    always_comb begin
        hit     = high_zero;
        rd_word = '0;
        unique case (idx)
            IDX_NP_TX:   rd_word = tx_view;
            IDX_NP_RX:   rd_word = np_rx_q;
            IDX_GIG_CFG: rd_word = cfg_q & GIG_CFG_WMASK;
            IDX_STAT:    rd_word = {15'h0000, page_rx_q};
            IDX_CTRL:    rd_word = {13'h0000, link_s, strap_s};
            default:     hit = 1'b0;
        endcase
        if (!high_zero) begin
            rd_word = '0;
        end
    end

    // ==========================================
    // Pin synchronisers
    angc_sync #(.W(3)) u_sync (
        .clk  (clk),
        .nrst (nrst),
        .d    ({link_up_pin, strap_fd, strap_hd}),
        .q    ({link_s, strap_s})
    );

    // ==========================================
    // APB answer: one wait state, registered outputs
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pready  <= 1'b0;
            prdata  <= '0;
            pslverr <= 1'b0;
        end else begin
            // Ready one cycle into the access phase, then drops
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~hit;
            if (psel & ~penable & ~pwrite) begin
                prdata <= {16'h0000, rd_word};
            end
        end
    end

    // Transfer completes on the edge where pready is seen high
    logic        done;                          // Completing edge
    assign done = psel & penable & pready;

    // ==========================================
    // Transmit next-page word
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            np_tx_q <= NP_TX_RST;
        end else if (done && wr_en && hit && idx == IDX_NP_TX) begin
            // Only bits 15,13,12,10..0 take the write
            np_tx_q <= pwdata[15:0] & NP_TX_WMASK;
        end
    end

    // Transmit toggle: seeded from inverse of local asym pause
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_toggle_q <= 1'b0;
        end else if (np_seed) begin
            tx_toggle_q <= ~local_asym_pause;
        end else if (np_sent) begin
            tx_toggle_q <= ~tx_toggle_q;
        end
    end

    // ==========================================
    // Received next-page word, read-only to software
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            np_rx_q <= NP_RX_RST;
        end else if (np_rx_valid) begin
            // Only a validated page is stored; toggle follows partner
            np_rx_q <= np_rx_word;
        end else if (np_seed) begin
            np_rx_q[NP_TOGGLE] <= ~partner_asym_pause;
        end
    end

    // Latched-high flag: set beats read clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            page_rx_q <= 1'b0;
        end else if (np_rx_valid) begin
            page_rx_q <= 1'b1;
        end else if (done && rd_en && hit && idx == IDX_STAT) begin
            page_rx_q <= 1'b0;
        end
    end

    // ==========================================
    // Gigabit configuration; duplex defaults from straps after release
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cfg_q        <= GIG_CFG_RST;
            strap_done_q <= 1'b0;
        end else if (done && wr_en && hit && idx == IDX_GIG_CFG) begin
            cfg_q        <= pwdata[15:0] & GIG_CFG_WMASK;
            strap_done_q <= 1'b1;
        end else if (!strap_done_q) begin
            // Straps are sampled two flops late, so wait a settle count
            cfg_q[CFG_FD] <= strap_s[1];
            cfg_q[CFG_HD] <= strap_s[0];
            strap_done_q  <= link_prev_q | strap_done_q | settle_q;
        end
    end

    // Settle marker: straps valid once the synchroniser has filled
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            settle_cnt_q <= 2'b00;
            settle_q     <= 1'b0;
        end else if (!settle_q) begin
            settle_cnt_q <= settle_cnt_q + 2'b01;
            settle_q     <= settle_cnt_q == 2'b10;
        end
    end

    // ==========================================
    // Core-facing outputs from flops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            np_tx_word             <= NP_TX_RST;
            test_mode              <= ANGC_TM_NORMAL;
            manual_role_enable     <= 1'b0;
            manual_role_value      <= 1'b0;
            multi_port             <= 1'b0;
            gig_full_duplex_advert <= 1'b1;
            gig_half_duplex_advert <= 1'b1;
        end else begin
            np_tx_word             <= tx_view;
            test_mode              <= cfg_q[CFG_TEST_HI:CFG_TEST_LO];
            manual_role_enable     <= cfg_q[CFG_MAN_EN];
            manual_role_value      <= cfg_q[CFG_MAN_VAL];
            multi_port             <= cfg_q[CFG_PORT];
            gig_full_duplex_advert <= cfg_q[CFG_FD];
            gig_half_duplex_advert <= cfg_q[CFG_HD];
        end
    end

    // ==========================================
    // Link-down detector and diagnostic launcher
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            link_prev_q <= 1'b0;
        end else begin
            link_prev_q <= link_s;
        end
    end

    // One pulse per link-down; re-armed only after link returns
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            diag_q     <= ANGC_DG_IDLE;
            diag_start <= 1'b0;
        end else begin
            diag_start <= 1'b0;
            unique case (diag_q)
                ANGC_DG_IDLE: begin
                    if (link_prev_q && !link_s && cfg_q[CFG_TDR]) begin
                        diag_start <= 1'b1;
                        diag_q     <= ANGC_DG_WAIT;
                    end
                end
                ANGC_DG_WAIT: begin
                    if (link_s) begin
                        diag_q <= ANGC_DG_IDLE;
                    end
                end
                default: diag_q <= ANGC_DG_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== angc_checker.sv
// Concurrent checks on the next-page and gigabit config register slice
`timescale 1ns/1ps
`default_nettype none
module angc_checker
    import angc_pkg::*;
#(
    parameter int AW = 12                                   // APB address width
) (
    input wire logic          clk, nrst, psel, penable, pwrite, pready,
    input wire logic [AW-1:0] paddr,
    input wire logic [31:0]   pwdata, prdata,
    input wire logic          np_sent, np_seed, local_asym_pause, diag_start,
    input wire logic [15:0]   np_tx_word,
    input wire logic [2:0]    test_mode,
    input wire logic          manual_role_enable, manual_role_value, multi_port,
    input wire logic          gig_full_duplex_advert, gig_half_duplex_advert
);
    // ==========================================
    // Completed transfers, decoded by word index
    logic tx_wr;                                            // Write to transmit word done
    logic cfg_wr;                                           // Write to config done
    logic cfg_rd;                                           // Read of config done
    assign tx_wr  = psel && penable && pready && pwrite && paddr[5:2] == IDX_NP_TX;
    assign cfg_wr = psel && penable && pready && pwrite && paddr[5:2] == IDX_GIG_CFG;
    assign cfg_rd = psel && penable && pready && !pwrite && paddr[5:2] == IDX_GIG_CFG;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // ==========================================
    // Outputs two edges after the completing edge
    AST_TX_WRITE: assert property (tx_wr |-> ##2
        (np_tx_word & NP_TX_WMASK) == ($past(pwdata[15:0], 2) & NP_TX_WMASK))
        else $error("transmit word differs from written value");
    AST_TX_RSVD: assert property (np_tx_word[NP_ACK] == 1'b0)
        else $error("reserved transmit bit set");
    // Toggle flips on every sent page, unless a reseed lands with it
    AST_TOGGLE_FLIP: assert property (np_sent && !np_seed |-> ##2
        np_tx_word[NP_TOGGLE] != $past(np_tx_word[NP_TOGGLE], 2))
        else $error("toggle did not flip");
    AST_TOGGLE_SEED: assert property (np_seed |-> ##2
        np_tx_word[NP_TOGGLE] == !$past(local_asym_pause, 2))
        else $error("toggle seed wrong");
    AST_TEST_MODE: assert property (cfg_wr |-> ##2 test_mode == $past(pwdata[15:13], 2))
        else $error("test mode output wrong");
    AST_ROLE: assert property (cfg_wr |-> ##2
        {manual_role_enable, manual_role_value} == $past(pwdata[12:11], 2))
        else $error("manual role outputs wrong");
    AST_PORT_DUPLEX: assert property (cfg_wr |-> ##2
        {multi_port, gig_full_duplex_advert, gig_half_duplex_advert} == $past(pwdata[10:8], 2))
        else $error("port type or duplex advert wrong");
    AST_DIAG_PULSE: assert property (diag_start |=> !diag_start)
        else $error("diagnostic start longer than one cycle");
    AST_CFG_RSVD: assert property (cfg_rd |-> prdata[6:0] == 7'h00)
        else $error("reserved config bits read nonzero");
    // ==========================================
    // Main scenarios reached
    COV_CFG_WR: cover property (cfg_wr);
    COV_SENT: cover property (np_sent);
    COV_DIAG: cover property (diag_start);
endmodule
bind angc_regs angc_checker #(.AW(AW)) u_chk (.clk, .nrst, .psel, .penable, .pwrite,
    .pready, .paddr, .pwdata, .prdata, .np_sent, .np_seed, .local_asym_pause,
    .diag_start, .np_tx_word, .test_mode, .manual_role_enable, .manual_role_value,
    .multi_port, .gig_full_duplex_advert, .gig_half_duplex_advert);
`default_nettype wire

// ===== angc_partner.sv
// Behavioural negotiation core and link partner feeding the page inputs
`timescale 1ns/1ps
`default_nettype none
module angc_partner (
    input  wire logic        clk,                 // Core clock
    output var  logic        np_sent,             // Pulse: page sent
    output var  logic        np_rx_valid,         // Pulse: partner page valid
    output var  logic [15:0] np_rx_word,          // Partner page word
    output var  logic        np_seed,             // Pulse: reseed toggles
    output var  logic        local_asym_pause,    // Local pause advert
    output var  logic        partner_asym_pause,  // Partner pause advert
    output var  logic        link_up_pin          // Link level
);
    // ==========================================
    // Quiet levels at time zero, link up
    initial begin
        {np_sent, np_rx_valid, np_seed, local_asym_pause, partner_asym_pause} = 5'h00;
        np_rx_word  = 16'h0000;
        link_up_pin = 1'b1;
    end
    // One validated page; the word turns over afterwards so a stale word never passes
    task automatic page(input logic [15:0] w);
        np_rx_word  <= w;
        np_rx_valid <= 1'b1;
        @(posedge clk);
        np_rx_valid <= 1'b0;
        np_rx_word  <= ~w;
        @(posedge clk);
    endtask
    // One page leaves for the partner
    task automatic tick_sent();
        np_sent <= 1'b1;
        @(posedge clk);
        np_sent <= 1'b0;
        @(posedge clk);
    endtask
    // New exchange with given base-page pause bits
    task automatic seed(input logic l, input logic p);
        local_asym_pause   <= l;
        partner_asym_pause <= p;
        np_seed            <= 1'b1;
        @(posedge clk);
        np_seed <= 1'b0;
        @(posedge clk);
    endtask
    // Link level from the medium
    task automatic link(input logic v);
        link_up_pin <= v;
        @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ===== test_autoneg_next_page_and_gig_config_regs.sv
// Self-checking bench for the next-page and gigabit config register slice
`timescale 1ns/1ps
`default_nettype none
module test_autoneg_next_page_and_gig_config_regs
    import angc_pkg::*;
;
    localparam logic [31:0] ALL = 32'hffffffff;             // Compare every bit
    logic        clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;                            // APB byte address
    logic [31:0] pwdata = 32'h0, prdata, rd_q;               // Write, read, captured
    logic        pready, pslverr, err_q;
    logic        np_sent, np_rx_valid, np_seed, local_asym_pause, partner_asym_pause;
    logic        link_up_pin, manual_role_enable, manual_role_value, multi_port;
    logic        gig_full_duplex_advert, gig_half_duplex_advert, diag_start;
    logic        strap_fd = 1'b1, strap_hd = 1'b1;           // Duplex strap pins
    logic [15:0] np_rx_word, np_tx_word;
    logic [2:0]  test_mode;
    int          error_cnt = 0, check_count = 0, cyc = 0, diag_cnt = 0;
    // ==========================================
    // Clock, design and partner
    always #10 clk = ~clk;
    angc_regs #(.AW(12)) uut (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .np_sent, .np_rx_valid, .np_rx_word, .np_seed,
        .local_asym_pause, .partner_asym_pause, .strap_fd, .strap_hd,
        .link_up_pin, .np_tx_word, .test_mode, .manual_role_enable, .manual_role_value,
        .multi_port, .gig_full_duplex_advert, .gig_half_duplex_advert, .diag_start);
    angc_partner lp (.clk, .np_sent, .np_rx_valid, .np_rx_word, .np_seed,
        .local_asym_pause, .partner_asym_pause, .link_up_pin);
    // ==========================================
    // Compare, APB transfer, verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
        check_count++;
        if ((got & m) !== (exp & m)) begin
            error_cnt++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        chk(32'(n < 50), 32'h1, 32'h1);
        rd_q    = prdata;
        err_q   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        apb(1'b1, a, {16'h0000, d});
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
        apb(1'b0, a, 32'h0);
        chk(rd_q, e, m);
    endtask
    task automatic test_done();
        $display("Checks %0d, errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Cycle ceiling and diagnostic pulse count
    always @(posedge clk) begin
        cyc++;
        if (diag_start === 1'b1) diag_cnt++;
        if (cyc == 20000) begin
            error_cnt++;
            test_done();
        end
    end
    // ==========================================
    // Sequence: resets, writes, toggles, pages, test codes, diagnostic
    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        repeat (8) @(posedge clk);
        rd(12'h01c, 32'h2001, ALL);
        rd(12'h020, 32'h2001, ALL);
        rd(12'h024, 32'h0300, ALL);
        wr(12'h01c, 16'hffff);
        rd(12'h01c, 32'hb7ff, ALL);
        chk(32'(np_tx_word), 32'hb7ff, ALL);
        wr(12'h01c, 16'h0000);
        rd(12'h01c, 32'h0000, ALL);
        lp.seed(1'b1, 1'b1);
        rd(12'h01c, 32'h0000, 32'h0800);
        lp.seed(1'b0, 1'b0);
        rd(12'h01c, 32'h0800, 32'h0800);
        rd(12'h020, 32'h2801, ALL);
        lp.tick_sent();
        rd(12'h01c, 32'h0000, 32'h0800);
        lp.page(16'hdc55);
        rd(12'h020, 32'hdc55, ALL);
        rd(12'h034, 32'h0001, 32'h1);
        rd(12'h034, 32'h0000, 32'h1);
        wr(12'h020, 16'h0000);
        rd(12'h020, 32'hdc55, ALL);
        lp.page(16'h2123);
        rd(12'h020, 32'h2123, ALL);
        // Every test code, with role, port and duplex bits alternating
        for (int i = 0; i < 8; i++) begin
            wr(12'h024, 16'(i << 13) | (i[0] ? 16'h1aff : 16'h057f));
            rd(12'h024, 32'(i << 13) | (i[0] ? 32'h1a80 : 32'h0500), ALL);
            chk(32'({test_mode, manual_role_enable, manual_role_value, multi_port,
                gig_full_duplex_advert, gig_half_duplex_advert}),
                32'(i << 5) | (i[0] ? 32'h1a : 32'h05), ALL);
        end
        // Link drop launches the diagnostic only when enabled
        wr(12'h024, 16'h0080);
        lp.link(1'b0);
        repeat (10) @(posedge clk);
        chk(32'(diag_cnt), 32'h1, ALL);
        lp.link(1'b1);
        repeat (10) @(posedge clk);
        wr(12'h024, 16'h0000);
        lp.link(1'b0);
        repeat (10) @(posedge clk);
        chk(32'(diag_cnt), 32'h1, ALL);
        rd(12'h000, 32'h0000, ALL);
        chk(32'(err_q), 32'h1, 32'h1);
        // Mid-run reset with full-duplex strap low: advert default follows strap
        strap_fd <= 1'b0;
        nrst     <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (8) @(posedge clk);
        rd(12'h024, 32'h0100, ALL);
        rd(12'h030, 32'h0001, ALL);
        chk(32'({gig_full_duplex_advert, gig_half_duplex_advert}), 32'h1, ALL);
        rd(12'h01c, 32'h2001, ALL);
        test_done();
    end
endmodule
`default_nettype wire
